// ---- urp_pkg.sv ----
package urp_pkg;
  localparam int unsigned FIFO_LVL_W = 7;
  localparam int unsigned TRIG_W = 4;
  // trigger fields count in steps of four characters
  localparam int unsigned TRIG_SHIFT = 2;
  localparam int unsigned MCR_RTS_BIT = 1;
  localparam int unsigned MCR_LOOP_BIT = 4;
  localparam int unsigned EFR_ARTS_BIT = 6;
  localparam int unsigned EFR_ACTS_BIT = 7;
  localparam int unsigned TCR_HALT_LSB = 0;
  localparam int unsigned TCR_RESUME_LSB = 4;
  localparam logic RTS_RESET_LVL = 1'b1;
  localparam logic LINE_IDLE_LVL = 1'b1;
  localparam logic TX_ALLOWED_RESET = 1'h0;
  localparam logic [1:0] SYNC_RESET = 2'h3;
  localparam logic [2:0] SYNC3_RESET = 3'h7;
endpackage

// ---- urp_top.sv ----
`timescale 1ns/1ps
module urp_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] chan_a_modem_ctrl,
  input wire logic [7:0] chan_b_modem_ctrl,
  input wire logic [7:0] chan_a_enhanced_features,
  input wire logic [7:0] chan_b_enhanced_features,
  input wire logic [7:0] chan_a_transmission_ctrl,
  input wire logic [7:0] chan_b_transmission_ctrl,
  input wire logic [6:0] chan_a_rx_fifo_level,
  input wire logic [6:0] chan_b_rx_fifo_level,
  input wire logic chan_a_tx_data,
  input wire logic chan_b_tx_data,
  input wire logic chan_a_serial_in,
  input wire logic chan_b_serial_in,
  input wire logic chan_a_clear_to_send_in,
  input wire logic chan_b_clear_to_send_in,
  output logic chan_a_serial_out,
  output logic chan_b_serial_out,
  output logic chan_a_request_to_send_out,
  output logic chan_b_request_to_send_out,
  output logic chan_a_rx_data,
  output logic chan_b_rx_data,
  output logic chan_a_tx_allowed,
  output logic chan_b_tx_allowed
);
  // the two channels share only clock, reset and clock enable
  urp_chan u_chan_a (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .modem_ctrl(chan_a_modem_ctrl),
    .enhanced_features(chan_a_enhanced_features),
    .transmission_ctrl(chan_a_transmission_ctrl),
    .rx_fifo_level(chan_a_rx_fifo_level),
    .tx_data(chan_a_tx_data),
    .serial_in(chan_a_serial_in),
    .cts_b_in(chan_a_clear_to_send_in),
    .serial_out(chan_a_serial_out),
    .rts_b_out(chan_a_request_to_send_out),
    .rx_data(chan_a_rx_data),
    .tx_allowed(chan_a_tx_allowed)
  );
  urp_chan u_chan_b (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .modem_ctrl(chan_b_modem_ctrl),
    .enhanced_features(chan_b_enhanced_features),
    .transmission_ctrl(chan_b_transmission_ctrl),
    .rx_fifo_level(chan_b_rx_fifo_level),
    .tx_data(chan_b_tx_data),
    .serial_in(chan_b_serial_in),
    .cts_b_in(chan_b_clear_to_send_in),
    .serial_out(chan_b_serial_out),
    .rts_b_out(chan_b_request_to_send_out),
    .rx_data(chan_b_rx_data),
    .tx_allowed(chan_b_tx_allowed)
  );
endmodule

// one channel; instantiated twice so the channels share no state
module urp_chan (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] modem_ctrl,
  input wire logic [7:0] enhanced_features,
  input wire logic [7:0] transmission_ctrl,
  input wire logic [6:0] rx_fifo_level,
  input wire logic tx_data,
  input wire logic serial_in,
  input wire logic cts_b_in,
  output logic serial_out,
  output logic rts_b_out,
  output logic rx_data,
  output logic tx_allowed
);
  // flow control state: halted once the receive fifo has reached the halt level
  typedef enum logic [0:0] {
    URP_FLOW_RUN = 1'b0,
    URP_FLOW_HALT = 1'b1
  } urp_flow_t;

  urp_flow_t flow_q;
  urp_flow_t flow_d;
  logic rx_pin;
  logic cts_pin_b;
  logic serial_out_q;
  logic rts_b_q;
  logic rx_data_q;
  logic tx_allowed_q;

  wire loop_en = modem_ctrl[urp_pkg::MCR_LOOP_BIT];
  wire sw_rts = modem_ctrl[urp_pkg::MCR_RTS_BIT];
  wire auto_rts = enhanced_features[urp_pkg::EFR_ARTS_BIT];
  wire auto_cts = enhanced_features[urp_pkg::EFR_ACTS_BIT];
  wire [urp_pkg::TRIG_W-1:0] halt_f =
    transmission_ctrl[urp_pkg::TCR_HALT_LSB +: urp_pkg::TRIG_W];
  wire [urp_pkg::TRIG_W-1:0] resume_f =
    transmission_ctrl[urp_pkg::TCR_RESUME_LSB +: urp_pkg::TRIG_W];
  // fields count in steps of four characters; a zero halt field halts auto mode from run at any fifo level
  wire [urp_pkg::FIFO_LVL_W-1:0] halt_lvl =
    urp_pkg::FIFO_LVL_W'(halt_f) << urp_pkg::TRIG_SHIFT;
  wire [urp_pkg::FIFO_LVL_W-1:0] resume_lvl =
    urp_pkg::FIFO_LVL_W'(resume_f) << urp_pkg::TRIG_SHIFT;

  // both pins are asynchronous to clk, so each gets its own filtered synchroniser
  urp_pin_sync #(
    .STAGE_RESET(urp_pkg::SYNC3_RESET),
    .LEVEL_RESET(urp_pkg::LINE_IDLE_LVL)
  ) u_rx_sync (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .pin(serial_in),
    .level(rx_pin)
  );
  urp_pin_sync #(
    .STAGE_RESET(urp_pkg::SYNC3_RESET),
    .LEVEL_RESET(urp_pkg::LINE_IDLE_LVL)
  ) u_cts_sync (
    .clk(clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .pin(cts_b_in),
    .level(cts_pin_b)
  );

  // leaving auto mode drops any halt at once
  always_comb begin
    flow_d = flow_q;
    unique case (flow_q)
      URP_FLOW_RUN: begin
        if (auto_rts && rx_fifo_level >= halt_lvl) begin
          flow_d = URP_FLOW_HALT;
        end
      end
      URP_FLOW_HALT: begin
        if (!auto_rts || rx_fifo_level <= resume_lvl) begin
          flow_d = URP_FLOW_RUN;
        end
      end
    endcase
  end

  // next state, not current, so the pin moves on the edge that sees the level cross
  wire halt_now = (flow_d == URP_FLOW_HALT);
  // auto mode still needs the software bit; it can only ever withdraw request-to-send
  wire rts_assert = sw_rts && !(auto_rts && halt_now);
  wire cts_ok = !auto_cts || !cts_pin_b;
  wire rx_src = loop_en ? tx_data : rx_pin;
  // in loopback the pin rests at the idle mark level, so the far end sees no start bit
  wire tx_pin = loop_en ? urp_pkg::LINE_IDLE_LVL : tx_data;

  // every output is registered so the pins never glitch while the controls change
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flow_q <= URP_FLOW_RUN;
      rts_b_q <= urp_pkg::RTS_RESET_LVL;
      serial_out_q <= urp_pkg::LINE_IDLE_LVL;
      rx_data_q <= urp_pkg::LINE_IDLE_LVL;
      tx_allowed_q <= urp_pkg::TX_ALLOWED_RESET;
    end else if (clk_en) begin
      flow_q <= flow_d;
      rts_b_q <= !rts_assert;
      serial_out_q <= tx_pin;
      rx_data_q <= rx_src;
      tx_allowed_q <= cts_ok;
    end
  end

  assign serial_out = serial_out_q;
  assign rts_b_out = rts_b_q;
  assign rx_data = rx_data_q;
  assign tx_allowed = tx_allowed_q;
endmodule

// three-flop pin synchroniser; a new level is taken only once stages two and three agree,
// which also throws away a pulse on the pin that lasts a single clock
module urp_pin_sync #(
  parameter logic [2:0] STAGE_RESET = urp_pkg::SYNC3_RESET,
  parameter logic LEVEL_RESET = urp_pkg::LINE_IDLE_LVL
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic pin,
  output logic level
);
  logic [2:0] stage_q;
  logic level_q;
  // only the second stage reads the first; the first may be metastable
  wire agree = (stage_q[1] == stage_q[2]);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_q <= STAGE_RESET;
      level_q <= LEVEL_RESET;
    end else if (clk_en) begin
      stage_q <= {stage_q[1:0], pin};
      if (agree) begin
        level_q <= stage_q[2];
      end
    end
  end

  assign level = level_q;
endmodule

// ---- urp_monitor.sv ----
`timescale 1ns/1ps
module urp_monitor (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] chan_a_modem_ctrl,
  input wire logic [7:0] chan_a_enhanced_features,
  input wire logic [7:0] chan_a_transmission_ctrl,
  input wire logic [6:0] chan_a_rx_fifo_level,
  input wire logic chan_a_tx_data,
  input wire logic chan_a_serial_out,
  input wire logic chan_a_request_to_send_out,
  input wire logic chan_a_rx_data,
  input wire logic chan_a_tx_allowed
);
  wire [7:0] mc = chan_a_modem_ctrl;
  wire ae = chan_a_enhanced_features[6];
  wire on = clk_en && mc[1] && ae;
  wire [6:0] lv = chan_a_rx_fifo_level;
  // trigger fields count in steps of four characters
  wire [6:0] hl = {1'h0, chan_a_transmission_ctrl[3:0], 2'h0};
  wire [6:0] rs = {1'h0, chan_a_transmission_ctrl[7:4], 2'h0};
  wire rts = chan_a_request_to_send_out;
  wire so = chan_a_serial_out;
  wire ta = chan_a_tx_allowed;
  wire ac = chan_a_enhanced_features[7];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence halt_s;
    on && lv >= hl;
  endsequence
  // the first low edge only starts the reset; outputs are settled from the second
  sequence in_rst_s;
    !rst_b ##1 !rst_b;
  endsequence
  rst_hold_a: assert property (disable iff (1'h0) in_rst_s |-> rts && so && !ta)
    else $error("pins active in reset");
  cts_off_a: assert property (clk_en && !ac |=> ta) else $error("cts off");
  rst_exit_a: assert property ($rose(rst_b) |-> rts) else $error("rts at release");
  sw_rts_a: assert property (clk_en && mc[1] && !ae |=> !rts) else $error("rts low");
  no_req_a: assert property (clk_en && !mc[1] |=> rts) else $error("rts high");
  halt_a: assert property (halt_s |=> rts) else $error("halt");
  hold_a: assert property (halt_s ##1 (on && lv > rs) |=> rts) else $error("hold");
  resume_a: assert property (on && lv <= rs && lv < hl |=> !rts) else $error("resume");
  loop_tx_a: assert property (clk_en && mc[4] |=> so) else $error("loop tx");
  loop_rx_a: assert property (clk_en && mc[4] |=> chan_a_rx_data == $past(chan_a_tx_data))
    else $error("loop rx");
endmodule
bind urp_top urp_monitor mon (
  .clk(clk),
  .rst_b(rst_b),
  .clk_en(clk_en),
  .chan_a_modem_ctrl(chan_a_modem_ctrl),
  .chan_a_enhanced_features(chan_a_enhanced_features),
  .chan_a_transmission_ctrl(chan_a_transmission_ctrl),
  .chan_a_rx_fifo_level(chan_a_rx_fifo_level),
  .chan_a_tx_data(chan_a_tx_data),
  .chan_a_serial_out(chan_a_serial_out),
  .chan_a_request_to_send_out(chan_a_request_to_send_out),
  .chan_a_rx_data(chan_a_rx_data),
  .chan_a_tx_allowed(chan_a_tx_allowed)
);

// ---- urp_peer.sv ----
`timescale 1ns/1ps
module urp_peer (
  input wire logic clk,
  input wire logic rts_b,
  input wire logic ready,
  output logic line,
  output logic cts_b
);
  logic [2:0] cnt = 3'h0;
  logic line_q = 1'h1;
  // each level stands eight clocks so the receiver's pin filter passes it;
  // the line idles high whenever request-to-send is not asserted
  always @(posedge clk) begin
    cnt <= cnt + 3'h1;
    if (rts_b !== 1'h0) begin
      line_q <= 1'h1;
    end else if (cnt == 3'h7) begin
      line_q <= ~line_q;
    end
  end
  assign line = line_q;
  assign cts_b = !ready;
endmodule

// ---- urp_tb.sv ----
`timescale 1ns/1ps
module tb;
  logic clk = 1'h0, rst_b = 1'h0, clk_en = 1'h1, rdy_a = 1'h1, t;
  logic [7:0] chan_a_modem_ctrl = 8'h00, chan_b_modem_ctrl = 8'h00;
  logic [7:0] chan_a_enhanced_features = 8'h00, chan_b_enhanced_features = 8'h00;
  logic [7:0] chan_a_transmission_ctrl = 8'h14, chan_b_transmission_ctrl = 8'h14;
  logic [6:0] chan_a_rx_fifo_level = 7'h00, chan_b_rx_fifo_level = 7'h00;
  logic chan_a_tx_data = 1'h1, chan_b_tx_data = 1'h1;
  wire chan_a_serial_in, chan_b_serial_in, chan_a_clear_to_send_in, chan_b_clear_to_send_in;
  wire chan_a_serial_out, chan_b_serial_out, chan_a_request_to_send_out;
  wire chan_b_request_to_send_out, chan_a_rx_data, chan_b_rx_data;
  wire chan_a_tx_allowed, chan_b_tx_allowed;
  int n_errors = 0, samples_checked = 0;
  urp_top uut (.*);
  urp_peer pa (.clk(clk), .rts_b(chan_a_request_to_send_out), .ready(rdy_a),
    .line(chan_a_serial_in), .cts_b(chan_a_clear_to_send_in));
  urp_peer pb (.clk(clk), .rts_b(chan_b_request_to_send_out), .ready(1'h1),
    .line(chan_b_serial_in), .cts_b(chan_b_clear_to_send_in));
  always #2.5 clk = ~clk;
  task automatic chk(input string nm, input logic s, input logic e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic lvl(input string nm, input logic [6:0] l, input logic e);
    chan_a_rx_fifo_level = l;
    tick(2);
    chk(nm, chan_a_request_to_send_out, e);
  endtask
  task automatic t_soft;
    rst_b = 1'h1;
    tick(1);
    chk("rts released", chan_a_request_to_send_out, 1'h1);
    chan_a_modem_ctrl = 8'h02;
    tick(2);
    chk("rts a", chan_a_request_to_send_out, 1'h0);
    chk("rts b", chan_b_request_to_send_out, 1'h1);
    clk_en = 1'h0;
    chan_a_modem_ctrl = 8'h00;
    lvl("rts frozen", 7'h00, 1'h0);
    clk_en = 1'h1;
    chan_a_modem_ctrl = 8'h02;
    rst_b = 1'h0;
    lvl("rts mid reset", 7'h00, 1'h1);
    rst_b = 1'h1;
    tick(1);
    lvl("rts again", 7'h00, 1'h0);
    $display("test soft done");
  endtask
  task automatic t_auto;
    chan_a_enhanced_features = 8'h40;
    lvl("halt", 7'h10, 1'h1);
    lvl("hold", 7'h05, 1'h1);
    lvl("resume", 7'h04, 1'h0);
    lvl("below halt", 7'h0f, 1'h0);
    chan_a_enhanced_features = 8'h80;
    lvl("auto off", 7'h10, 1'h0);
    rdy_a = 1'h0;
    tick(6);
    chk("cts stop", chan_a_tx_allowed, 1'h0);
    chk("b cts", chan_b_tx_allowed, 1'h1);
    rdy_a = 1'h1;
    tick(6);
    chk("cts go", chan_a_tx_allowed, 1'h1);
    $display("test auto done");
  endtask
  task automatic t_loop;
    chan_a_modem_ctrl = 8'h12;
    tick(1);
    for (int i = 0; i < 4; i++) begin
      t = i > 1;
      chan_a_tx_data = t;
      chan_b_tx_data = !t;
      tick(1);
      chk("loop rx", chan_a_rx_data, t);
      chk("loop tx", chan_a_serial_out, 1'h1);
      chk("b tx", chan_b_serial_out, !t);
    end
    $display("test loop done");
  endtask
  task automatic t_pin;
    logic prev;
    int k;
    chan_b_modem_ctrl = 8'h02;
    for (int j = 0; j < 2; j++) begin
      prev = chan_b_serial_in;
      k = 0;
      while (chan_b_serial_in === prev && k < 20) begin
        tick(1);
        k++;
      end
      if (chan_b_serial_in === prev) begin
        chk("pin wait", 1'h0, 1'h1);
        final_report();
      end
      tick(6);
      chk("pin rx", chan_b_rx_data, chan_b_serial_in);
    end
    $display("test pin done");
  endtask
  task automatic final_report;
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    tick(12);
    t_soft();
    t_auto();
    t_loop();
    t_pin();
    final_report();
  end
endmodule
